// ==== design/qpsc_regs.vh ====
`ifndef QPSC_REGS_VH
`define QPSC_REGS_VH

// ----------------------------------------------------------------------------
// Bus register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define QPSC_STATUS_OFS      8'h00
`define QPSC_WIPERS_OFS      8'h04
`define QPSC_CTRL_OFS        8'h08

// Status word field positions.
`define QPSC_ST_RUN_BIT      0
`define QPSC_ST_WIP_BIT      1
`define QPSC_ST_RECALL_BIT   2
`define QPSC_ST_BUSY_BIT     3

// Control word field positions and reset values.
`define QPSC_CTRL_SUPPLY_BIT 0
`define QPSC_CTRL_RESET      1'b0

// ----------------------------------------------------------------------------
// Serial register map and access control fields
// ----------------------------------------------------------------------------
`define QPSC_ID_PREFIX       4'ha
`define QPSC_REG_GP_FIRST    4'h4
`define QPSC_REG_GP_LAST     4'h6
`define QPSC_REG_ACR         4'h8
`define QPSC_ACR_VOL_BIT     7
`define QPSC_ACR_POWER_DOWN_CONTROL_BIT    6
`define QPSC_ACR_WIP_BIT     5
`define QPSC_ACR_VOL_RESET   1'b0
`define QPSC_ACR_POWER_DOWN_CONTROL_RESET  1'b1
`define QPSC_WIPER_RESET     7'h40
`define QPSC_IVR_INIT        7'h40
`define QPSC_GP_INIT         8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define QPSC_CLK_PERIOD_NS   5
`define QPSC_NVW_TIME_MS     20
`define QPSC_NVW_CYCLES      ((`QPSC_NVW_TIME_MS * 1000000) / `QPSC_CLK_PERIOD_NS)

`endif

// ==== design/qpsc_sync.v ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Two-flop synchroniser for pins from outside the clock domain
// ----------------------------------------------------------------------------
module qpsc_sync #(
  parameter WIDTH = 1
)
(
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_reg;

  // Resets high because the open-drain lines idle high.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= {WIDTH{1'b1}};
      q        <= {WIDTH{1'b1}};
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // qpsc_sync

`default_nettype wire

// ==== design/qpsc_ctrl.v ====
`timescale 1ns/1ps
`default_nettype none
`include "qpsc_regs.vh"

module qpsc_ctrl #(
  parameter [21:0] NV_WRITE_CYCLES = `QPSC_NVW_CYCLES
)
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire [2:0]  addr_select_pins,
  input  wire        power_down_control,
  output reg  [3:0]  high_terminal_en,
  output reg  [3:0]  wiper_low_short,
  output reg  [27:0] wiper_tap
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_DEV  = 3'd1;
  localparam [2:0] ST_REG  = 3'd2;
  localparam [2:0] ST_WR   = 3'd3;
  localparam [2:0] ST_RD   = 3'd4;

  // --------------------------------------------------------------------------
  // Pin synchronisation and serial edge detection
  // --------------------------------------------------------------------------
  wire [5:0] sync_q;
  wire       scl_s  = sync_q[5];
  wire       sda_s  = sync_q[4];
  wire       pdc_s  = sync_q[3];
  wire [2:0] addr_s = sync_q[2:0];

  qpsc_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({scl_in, sda_in, power_down_control, addr_select_pins}),
    .q     (sync_q)
  );

  reg scl_d_reg;
  reg sda_d_reg;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  wire scl_rise  = scl_s & ~scl_d_reg;
  wire scl_fall  = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg [2:0]  state_reg;
  reg [3:0]  bitcnt_reg;
  reg [7:0]  shift_reg;
  reg [7:0]  tx_reg;
  reg        mack_reg;
  reg [3:0]  reg_ptr_reg;
  reg [27:0] wiper_pos_reg;
  reg [27:0] stored_initial_value_reg;
  reg [23:0] gp_reg;
  reg        acr_vol_reg;
  reg        acr_power_down_control_reg;
  reg        wip_reg;
  reg        nv_pend_reg;
  reg [21:0] nv_cnt_reg;
  reg        recall_done_reg;
  reg        supply_ok_reg;

  wire [7:0] access_control_reg = {acr_vol_reg, acr_power_down_control_reg, wip_reg, 5'h00};
  wire       run = pdc_s & acr_power_down_control_reg;
  wire [4:0] wsel = {reg_ptr_reg[1:0], 3'b000} - {3'b000, reg_ptr_reg[1:0]};
  wire [4:0] gsel = {reg_ptr_reg[1:0], 3'b000};

  reg [7:0] rd_byte;

  always @*
  begin
    rd_byte = 8'h00;
    if (reg_ptr_reg < `QPSC_REG_GP_FIRST)
    begin
      if (acr_vol_reg)
        rd_byte = {1'b0, wiper_pos_reg[wsel +: 7]};
      else
        rd_byte = {1'b0, stored_initial_value_reg[wsel +: 7]};
    end
    else if (reg_ptr_reg <= `QPSC_REG_GP_LAST)
      rd_byte = gp_reg[gsel +: 8];
    else if (reg_ptr_reg == `QPSC_REG_ACR)
      rd_byte = access_control_reg;
  end

  // --------------------------------------------------------------------------
  // Serial slave, register writes, recall and self-timed store
  // --------------------------------------------------------------------------
  // Storage resets to a fixed image; the stored values cannot outlive reset here.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg                <= ST_IDLE;
      bitcnt_reg               <= 4'h0;
      shift_reg                <= 8'h00;
      tx_reg                   <= 8'h00;
      mack_reg                 <= 1'b1;
      reg_ptr_reg              <= 4'h0;
      sda_oe                   <= 1'b0;
      wiper_pos_reg            <= {4{`QPSC_WIPER_RESET}};
      stored_initial_value_reg <= {4{`QPSC_IVR_INIT}};
      gp_reg                   <= {3{`QPSC_GP_INIT}};
      acr_vol_reg              <= `QPSC_ACR_VOL_RESET;
      acr_power_down_control_reg             <= `QPSC_ACR_POWER_DOWN_CONTROL_RESET;
      wip_reg                  <= 1'b0;
      nv_pend_reg              <= 1'b0;
      nv_cnt_reg               <= 22'h000000;
      recall_done_reg          <= 1'b0;
    end
    else
    begin
      if (supply_ok_reg && !recall_done_reg)
      begin
        wiper_pos_reg   <= stored_initial_value_reg;
        recall_done_reg <= 1'b1;
      end
      if (wip_reg)
      begin
        if (nv_cnt_reg == 22'h000000)
          wip_reg <= 1'b0;
        else
          nv_cnt_reg <= nv_cnt_reg - 22'h000001;
      end
      if (start_det)
      begin
        // A START is ignored until the power-up recall has finished.
        state_reg  <= recall_done_reg ? ST_DEV : ST_IDLE;
        bitcnt_reg <= 4'h0;
        sda_oe     <= 1'b0;
      end
      else if (stop_det)
      begin
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
        if (nv_pend_reg && !wip_reg)
        begin
          wip_reg     <= 1'b1;
          nv_cnt_reg  <= NV_WRITE_CYCLES - 22'h000001;
          nv_pend_reg <= 1'b0;
        end
      end
      else if (state_reg != ST_IDLE)
      begin
        if (scl_rise)
        begin
          if (bitcnt_reg < 4'h8)
          begin
            shift_reg  <= {shift_reg[6:0], sda_s};
            bitcnt_reg <= bitcnt_reg + 4'h1;
          end
          else
          begin
            mack_reg   <= sda_s;
            bitcnt_reg <= 4'h9;
          end
        end
        else if (scl_fall)
        begin
          if (bitcnt_reg == 4'h8)
          begin
            sda_oe <= 1'b0;
            case (state_reg)
              ST_DEV:
              begin
                if (shift_reg[7:1] == {`QPSC_ID_PREFIX, addr_s})
                begin
                  sda_oe    <= 1'b1;
                  state_reg <= shift_reg[0] ? ST_RD : ST_REG;
                end
                else
                  state_reg <= ST_IDLE;
              end
              ST_REG:
              begin
                reg_ptr_reg <= shift_reg[3:0];
                sda_oe      <= 1'b1;
                state_reg   <= ST_WR;
              end
              ST_WR:
              begin
                sda_oe      <= 1'b1;
                reg_ptr_reg <= reg_ptr_reg + 4'h1;
                // Writes are dropped while a store is running.
                if (!wip_reg)
                begin
                  if (reg_ptr_reg < `QPSC_REG_GP_FIRST)
                  begin
                    wiper_pos_reg[wsel +: 7] <= shift_reg[6:0];
                    if (!acr_vol_reg)
                    begin
                      stored_initial_value_reg[wsel +: 7] <= shift_reg[6:0];
                      nv_pend_reg <= 1'b1;
                    end
                  end
                  else if (reg_ptr_reg <= `QPSC_REG_GP_LAST)
                  begin
                    if (!acr_vol_reg)
                    begin
                      gp_reg[gsel +: 8] <= shift_reg;
                      nv_pend_reg       <= 1'b1;
                    end
                  end
                  else if (reg_ptr_reg == `QPSC_REG_ACR)
                  begin
                    acr_vol_reg  <= shift_reg[`QPSC_ACR_VOL_BIT];
                    acr_power_down_control_reg <= shift_reg[`QPSC_ACR_POWER_DOWN_CONTROL_BIT];
                  end
                end
              end
              default:
                sda_oe <= 1'b0;
            endcase
          end
          else if (bitcnt_reg == 4'h9)
          begin
            bitcnt_reg <= 4'h0;
            sda_oe     <= 1'b0;
            if (state_reg == ST_RD)
            begin
              if (mack_reg)
                state_reg <= ST_IDLE;
              else
              begin
                sda_oe      <= ~rd_byte[7];
                tx_reg      <= {rd_byte[6:0], 1'b0};
                reg_ptr_reg <= reg_ptr_reg + 4'h1;
              end
            end
          end
          else if (state_reg == ST_RD && bitcnt_reg != 4'h0)
          begin
            sda_oe <= ~tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Potentiometer switch outputs
  // --------------------------------------------------------------------------
  // The tap code is the switch index counted from the low end, so the
  // all-ones code picks the switch next to the high end.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sda_out          <= 1'b0;
      high_terminal_en <= 4'h0;
      wiper_low_short  <= 4'hf;
      wiper_tap        <= {4{`QPSC_WIPER_RESET}};
    end
    else
    begin
      sda_out          <= 1'b0;
      high_terminal_en <= {4{run}};
      wiper_low_short  <= {4{~run}};
      wiper_tap        <= wiper_pos_reg;
    end
  end

  // --------------------------------------------------------------------------
  // AHB-Lite register slave
  // --------------------------------------------------------------------------
  wire       ahb_take = hsel & htrans[1] & hready;
  reg        ahb_wr_reg;
  reg [7:0]  ahb_addr_reg;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      hrdata        <= 32'h00000000;
      ahb_wr_reg    <= 1'b0;
      ahb_addr_reg  <= 8'h00;
      supply_ok_reg <= `QPSC_CTRL_RESET;
    end
    else
    begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      ahb_wr_reg <= ahb_take & hwrite;
      if (ahb_take)
      begin
        ahb_addr_reg <= haddr[7:0];
        hrdata       <= 32'h00000000;
        if (!hwrite && haddr[31:8] == 24'h000000)
        begin
          case (haddr[7:0])
            `QPSC_STATUS_OFS:
            begin
              hrdata[`QPSC_ST_RUN_BIT]    <= run;
              hrdata[`QPSC_ST_WIP_BIT]    <= wip_reg;
              hrdata[`QPSC_ST_RECALL_BIT] <= recall_done_reg;
              hrdata[`QPSC_ST_BUSY_BIT]   <= (state_reg != ST_IDLE);
            end
            `QPSC_WIPERS_OFS:
              hrdata <= {4'h0, wiper_pos_reg};
            `QPSC_CTRL_OFS:
              hrdata[`QPSC_CTRL_SUPPLY_BIT] <= supply_ok_reg;
            default:
              hrdata <= 32'h00000000;
          endcase
        end
      end
      // The supply flag only ever rises; clearing it cannot undo a recall.
      if (ahb_wr_reg && ahb_addr_reg == `QPSC_CTRL_OFS)
        supply_ok_reg <= supply_ok_reg | hwdata[`QPSC_CTRL_SUPPLY_BIT];
    end
  end

endmodule // qpsc_ctrl

`default_nettype wire

// ==== sim/qpsc_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module qpsc_ctrl_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        power_down_control,
  input wire logic [3:0]  high_terminal_en,
  input wire logic [3:0]  wiper_low_short,
  input wire logic [27:0] wiper_tap
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Six samples cover the pin synchroniser and the output register.
  sequence pin_low_s;
    !power_down_control [*6];
  endsequence
  sequence scl_rise_s;
    $rose(scl_in);
  endsequence
  sda_low_only_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  oe_after_fall_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line changed while serial clock high");
  oe_hold_a: assert property (scl_rise_s |=> $stable(sda_oe) [*5])
    else $error("data line moved during clock high phase");
  pin_gates_run_a: assert property (pin_low_s |-> high_terminal_en == 4'h0)
    else $error("pot runs with shutdown pin low");
  shut_pair_a: assert property (wiper_low_short == ~high_terminal_en)
    else $error("wiper short and high end disagree");
  tap_kept_a: assert property ($changed(high_terminal_en) |-> $stable(wiper_tap))
    else $error("wiper moved on shutdown change");
  power_up_mid_a: assert property ($rose(hresetn) |-> wiper_tap == {4{7'h40}})
    else $error("wipers not at mid scale after reset");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("register bus stalled or errored");
endmodule // qpsc_ctrl_asserts

bind qpsc_ctrl qpsc_ctrl_asserts i_chk (.hclk, .hresetn, .hreadyout, .hresp, .scl_in,
  .sda_out, .sda_oe, .power_down_control, .high_terminal_en, .wiper_low_short, .wiper_tap);
`default_nettype wire

// ==== sim/qpsc_i2c_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module qpsc_i2c_master (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // Clock idles high between frames; the data line is only ever pulled low.
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic bitx(input logic b, output logic r);
    sda_pull = !b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
    #20;
  endtask
  task automatic start;
    sda_pull = 1'b0;
    #20 scl = 1'b1;
    #20 sda_pull = 1'b1;
    #20 scl = 1'b0;
    #20;
  endtask
  task automatic stop;
    sda_pull = 1'b1;
    #20 scl = 1'b1;
    #20 sda_pull = 1'b0;
    #40;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // Always ends with a not-acknowledge, so single-byte reads only.
  task automatic rbyte(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(1'b1, r);
  endtask
endmodule // qpsc_i2c_master
`default_nettype wire

// ==== sim/qpsc_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "qpsc_regs.vh"
`define check(g, e) \
  begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module qpsc_ctrl_test;
  logic             hclk, hresetn, hsel, hwrite, pull, pdc, a;
  logic [1:0]       htrans;
  logic [2:0]       hsize, pins;
  logic [7:0]       d;
  logic [31:0]      haddr, hwdata, r;
  wire logic        hreadyout, hresp, sda_out, sda_oe, scl, sda;
  wire logic [3:0]  hten, wls;
  wire logic [27:0] tap;
  wire logic [31:0] hrdata;
  int               err_count, comparisons;
  assign sda = !((sda_oe && !sda_out) || pull);
  qpsc_ctrl #(.NV_WRITE_CYCLES(22'd50)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .addr_select_pins(pins),
    .power_down_control(pdc), .high_terminal_en(hten), .wiper_low_short(wls),
    .wiper_tap(tap));
  qpsc_i2c_master i_mst (.scl, .sda_pull(pull), .sda);
  // --------------------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic iwr(input logic [3:0] ra, input logic [7:0] wd);
    repeat (60) @(posedge hclk);
    // Frames start on a falling clock edge so that no line moves at a sampling edge.
    @(negedge hclk);
    i_mst.start;
    i_mst.wbyte({4'ha, pins, 1'b0}, a);
    `check(a, 1'b1)
    i_mst.wbyte({4'h0, ra}, a);
    i_mst.wbyte(wd, a);
    `check(a, 1'b1)
    i_mst.stop;
  endtask
  task automatic ird(input logic [3:0] ra);
    @(negedge hclk);
    i_mst.start;
    i_mst.wbyte({4'ha, pins, 1'b0}, a);
    i_mst.wbyte({4'h0, ra}, a);
    i_mst.start;
    i_mst.wbyte({4'ha, pins, 1'b1}, a);
    `check(a, 1'b1)
    i_mst.rbyte(d);
    i_mst.stop;
  endtask
  task automatic settle;
    repeat (8) @(posedge hclk);
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_power_up;
    settle;
    `check(tap, {4{7'h40}})
    `check(hten, 4'hf)
    ahb(1'b0, `QPSC_STATUS_OFS, 32'h0);
    `check(r[`QPSC_ST_RECALL_BIT], 1'b0)
    ahb(1'b1, `QPSC_CTRL_OFS, 32'h1);
    ahb(1'b0, `QPSC_STATUS_OFS, 32'h0);
    `check(r[`QPSC_ST_RECALL_BIT], 1'b1)
    ahb(1'b0, `QPSC_WIPERS_OFS, 32'h0);
    `check(r, {4'h0, {4{7'h40}}})
    ahb(1'b0, 8'h0c, 32'h0);
    `check(r, 32'h0)
  endtask
  task automatic t_address;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge hclk);
      pins <= k[2:0];
      // Pins pass a synchroniser, so they settle well before START.
      settle;
      @(negedge hclk);
      i_mst.start;
      i_mst.wbyte({4'ha, k[2:0] ^ 3'h1, 1'b0}, a);
      `check(a, 1'b0)
      i_mst.stop;
      ird(4'h8);
      `check(d, 8'h40)
    end
  endtask
  task automatic t_wiper;
    iwr(4'h8, 8'hc0);
    iwr(4'h0, 8'h7f);
    iwr(4'h3, 8'h00);
    settle;
    `check(tap[6:0], 7'h7f)
    `check(tap[27:21], 7'h00)
    ird(4'h0);
    `check(d, 8'h7f)
  endtask
  task automatic t_shutdown;
    pdc <= 1'b0;
    settle;
    `check(hten, 4'h0)
    `check(wls, 4'hf)
    iwr(4'h1, 8'h11);
    settle;
    `check(tap[13:7], 7'h11)
    `check(tap[6:0], 7'h7f)
    pdc <= 1'b1;
    settle;
    `check(hten, 4'hf)
    `check(wls, 4'h0)
    iwr(4'h8, 8'h80);
    settle;
    `check(hten, 4'h0)
    ird(4'h8);
    `check(d, 8'h80)
    iwr(4'h8, 8'h40);
    settle;
    `check(hten, 4'hf)
  endtask
  task automatic t_nv_write;
    iwr(4'h2, 8'h2a);
    ahb(1'b0, `QPSC_STATUS_OFS, 32'h0);
    `check(r[`QPSC_ST_WIP_BIT], 1'b1)
    `check(tap[20:14], 7'h2a)
    repeat (60) @(posedge hclk);
    ahb(1'b0, `QPSC_STATUS_OFS, 32'h0);
    `check(r[`QPSC_ST_WIP_BIT], 1'b0)
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = !hclk;
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    pins = 3'h5;
    pdc = 1'b1;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_power_up;
    t_address;
    t_wiper;
    @(posedge hclk);
    t_shutdown;
    t_nv_write;
    test_done;
  end
  initial
  begin
    #300000;
    err_count++;
    test_done;
  end
endmodule // qpsc_ctrl_test
`default_nettype wire
